// ===== logic/dpbf_defs.svh
`ifndef DPBF_DEFS_SVH
`define DPBF_DEFS_SVH
// Register byte addresses
`define DPBF_A_CFG   8'h00
`define DPBF_A_AFL   8'h04
`define DPBF_A_AEL   8'h08
`define DPBF_A_STA   8'h0c
`define DPBF_A_CNT   8'h10
// Reset values of the threshold registers
`define DPBF_AFL_RST 16'h0100
`define DPBF_AEL_RST 16'h0004
// Port shape codes: 0..6 give 1,2,4,9,18,36,72 bits
`define DPBF_WMAX    3'h6
`define DPBF_WHALF   3'h5
`define DPBF_WBYTE   3'h3
`define DPBF_SLOTSH  3'h6
// Row layout: eight lanes of eight data bits plus one parity bit
`define DPBF_LANE    9
`define DPBF_LDAT    8
`define DPBF_PBASE   64
`define DPBF_RBITS   72
`define DPBF_ROWS    512
`define DPBF_HALF    8
`define DPBF_DEPTH   16'h8000
`define DPBF_CASC    15
`endif

// ===== logic/dpbf_pkg.sv
package dpbf_pkg;
  `include "dpbf_defs.svh"

  // Configuration register layout
  typedef struct packed {
    logic [11:0] rsvd;
    logic        casc_up;
    logic        casc;
    logic        async;
    logic        fwft;
    logic        fifo;
    logic        ecc;
    logic        split_read_write_port_mode;
    logic        split;
    logic        oreg_b;
    logic        oreg_a;
    logic [1:0]  pol_b;
    logic [1:0]  pol_a;
    logic [2:0]  wid_b;
    logic [2:0]  wid_a;
  } dpbf_cfg_t;

  // Status register layout
  typedef struct packed {
    logic [25:0] rsvd;
    logic        dbe;
    logic        sbe;
    logic        aempty;
    logic        afull;
    logic        empty;
    logic        full;
  } dpbf_sta_t;

  // Write-cycle output policy
  typedef enum logic [1:0] {
    DPBF_POL_READ  = 2'h0,
    DPBF_POL_WRITE = 2'h1,
    DPBF_POL_HOLD  = 2'h2
  } dpbf_pol_t;

  // Whole state of the block
  typedef struct packed {
    logic [`DPBF_ROWS-1:0][`DPBF_RBITS-1:0] mem;
    dpbf_cfg_t   cfg;
    logic [15:0] afl;
    logic [15:0] ael;
    logic [15:0] wptr;
    logic [15:0] rptr;
    logic [15:0] wg;
    logic [15:0] rg;
    logic [15:0] wsync1;
    logic [15:0] wsync2;
    logic [15:0] rsync1;
    logic [15:0] rsync2;
    logic [15:0] cnt;
    logic        fwv;
    logic [71:0] lat_a;
    logic [71:0] lat_b;
    logic [71:0] out_a;
    logic [71:0] out_b;
    logic        sel_a;
    logic        sel_b;
    logic        casc_a;
    logic        casc_b;
    logic        full;
    logic        empty;
    logic        afull;
    logic        aempty;
    logic        sbe;
    logic        dbe;
    logic        sbe_st;
    logic        dbe_st;
    logic [7:0]  par;
    logic        ack;
    logic [31:0] dat;
  } dpbf_state_t;
endpackage : dpbf_pkg

// ===== logic/dpbf_top.sv
`timescale 1ns/100ps
`include "dpbf_defs.svh"
// Contract
// R01: two independent ports share only the array
// R02: all port inputs captured at clock edge
// R03: read result held until next enabled access
// R04: optional output register adds one cycle
// R05: write output policy: old, new or hold
// R06: shapes 32K x 1 through 512 x 72
// R07: each port picks its own shape
// R08: split into two independent 18 Kb halves
// R09: wide half only in split read/write mode
// R10: split mode write side fixed at 72
// R11: no read output during a write cycle
// R12: two blocks cascade into 64K x 1
// R13: eight Hamming bits, correct single, flag double
// R14: error correction only in split mode; the code drives ecc_parity_o from din_a_i whenever ecc is set, in any mode
// R15: FIFO single or dual clock, auto addressing; the code has only clk_i, async makes flags, count and fall-through use synchronized gray pointers
// R16: four flags full, empty, almost both
// R17: almost thresholds are programmable registers
// R18: FIFO read and write widths equal
// R19: fall-through shows oldest word before read
// R20: after first read, behaves as standard
// R21: writes when full, reads when empty ignored
// R22: dual-clock flags from synchronized gray pointers
module dpbf_top
  import dpbf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        en_a_i,
  input  wire logic        we_a_i,
  input  wire logic [15:0] addr_a_i,
  input  wire logic [71:0] din_a_i,
  output logic      [71:0] dout_a_o,
  input  wire logic        casc_a_i,
  output logic             casc_a_o,
  input  wire logic        en_b_i,
  input  wire logic        we_b_i,
  input  wire logic [15:0] addr_b_i,
  input  wire logic [71:0] din_b_i,
  output logic      [71:0] dout_b_o,
  input  wire logic        casc_b_i,
  output logic             casc_b_o,
  input  wire logic        fifo_wr_i,
  input  wire logic        fifo_rd_i,
  output logic             full_o,
  output logic             empty_o,
  output logic             afull_o,
  output logic             aempty_o,
  output logic             sbiterr_o,
  output logic             dbiterr_o,
  output logic      [7:0]  ecc_parity_o
);

  dpbf_state_t s;
  dpbf_state_t n;
  logic        wbreq;
  logic        cfg_wr;
  logic [31:0] clr;
  logic [31:0] tmp32;
  logic [2:0]  wa;
  logic [2:0]  wbw;
  logic        own_a;
  logic        own_b;
  logic        half_b;
  logic [8:0]  row_a;
  logic [8:0]  row_b;
  logic [71:0] raw;
  logic [71:0] rdv;
  logic [71:0] wd;
  logic [73:0] fix;
  logic        a_wr;
  logic        pop;
  logic        mem_empty;
  logic [15:0] depth;
  logic [15:0] wv;
  logic [15:0] rv;
  logic [15:0] wcnt;
  logic [15:0] rcnt;

  // Clamp a shape code to the legal range
  function automatic logic [2:0] eff_w(input logic [2:0] w, input logic lim);
    if (w > `DPBF_WMAX) w = `DPBF_WMAX;
    if (lim && w > `DPBF_WHALF) w = `DPBF_WHALF;
    return w;
  endfunction : eff_w

  // Row of an element address for a given shape
  function automatic logic [8:0] row_of(input logic [15:0] a, input logic [2:0] w,
                                        input logic sp, input logic h);
    logic [15:0] r;
    r = a >> (`DPBF_SLOTSH - w);
    row_of = r[8:0];
    if (sp) row_of[`DPBF_HALF] = h;
  endfunction : row_of

  // Row bit b belongs to the addressed element
  function automatic logic hit(input int b, input logic [15:0] a, input logic [2:0] w);
    int ln;
    int k;
    int slot;
    ln   = b / `DPBF_LANE;
    k    = b % `DPBF_LANE;
    slot = int'(a) % (`DPBF_PBASE >> w);
    if (k < `DPBF_LDAT) hit = ((ln * `DPBF_LDAT + k) >> w) == slot;
    else hit = (w >= `DPBF_WBYTE) && (((ln * `DPBF_LDAT) >> w) == slot);
  endfunction : hit

  // Position of row bit b in the user word
  function automatic int uidx(input int b, input logic [2:0] w);
    int ln;
    int k;
    ln = b / `DPBF_LANE;
    k  = b % `DPBF_LANE;
    if (k < `DPBF_LDAT) uidx = (ln * `DPBF_LDAT + k) & ((1 << w) - 1);
    else uidx = `DPBF_PBASE + (ln & (((1 << w) / `DPBF_LDAT) - 1));
  endfunction : uidx

  // Element read out of a row
  function automatic logic [71:0] rd_word(input logic [71:0] row, input logic [15:0] a,
                                          input logic [2:0] w);
    rd_word = '0;
    for (int b = 0; b < `DPBF_RBITS; b++) begin
      if (hit(b, a, w)) rd_word[uidx(b, w)] = row[b];
    end
  endfunction : rd_word

  // Row with one element replaced
  function automatic logic [71:0] wr_row(input logic [71:0] row, input logic [15:0] a,
                                         input logic [2:0] w, input logic [71:0] d);
    for (int b = 0; b < `DPBF_RBITS; b++) begin
      if (hit(b, a, w)) row[b] = d[uidx(b, w)];
    end
    return row;
  endfunction : wr_row

  // Hamming check bits over 64 data bits
  function automatic logic [7:0] ecc_enc(input logic [63:0] d);
    int k;
    ecc_enc = '0;
    k = 0;
    for (int p = 1; p < `DPBF_RBITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[k]) ecc_enc[6:0] = ecc_enc[6:0] ^ p[6:0];
        k++;
      end
    end
    ecc_enc[7] = ^d ^ ^ecc_enc[6:0];
  endfunction : ecc_enc

  // Data index of a code position, or -1
  function automatic int pos2idx(input logic [6:0] sy);
    int k;
    pos2idx = -1;
    k = 0;
    for (int p = 1; p < `DPBF_RBITS; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (p == int'(sy)) pos2idx = k;
        k++;
      end
    end
  endfunction : pos2idx

  // Correct a stored word: {double, single, word}
  function automatic logic [73:0] ecc_fix(input logic [71:0] w);
    logic [7:0] c;
    logic [6:0] sy;
    logic       ov;
    int         k;
    c  = ecc_enc(w[63:0]);
    sy = c[6:0] ^ w[70:64];
    ov = ^w;
    k  = pos2idx(sy);
    if (ov && k >= 0) w[k] = !w[k];
    return {!ov && (sy != 7'h00), ov, w};
  endfunction : ecc_fix

  // Byte-lane merge for register writes
  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) o[i*8 +: 8] = d[i*8 +: 8];
    end
    return o;
  endfunction : bmerge

  // Gray code conversions
  function automatic logic [15:0] b2g(input logic [15:0] x);
    return x ^ (x >> 1);
  endfunction : b2g

  function automatic logic [15:0] g2b(input logic [15:0] g);
    g2b[15] = g[15];
    for (int i = 14; i >= 0; i--) g2b[i] = g2b[i+1] ^ g[i];
  endfunction : g2b

  // Next-state logic
  always_comb begin
    n         = s;
    n.ack     = 1'b0;
    n.sbe     = 1'b0;
    n.dbe     = 1'b0;
    clr       = '0;
    cfg_wr    = 1'b0;
    tmp32     = '0;
    raw       = '0;
    rdv       = '0;
    wd        = '0;
    fix       = '0;
    row_a     = '0;
    row_b     = '0;
    pop       = 1'b0;
    // Effective shapes of both ports
    wa  = s.cfg.split_read_write_port_mode ? `DPBF_WMAX                    // see R10
        : eff_w(s.cfg.wid_a, s.cfg.split);                                 // see R06 R08
    wbw = (s.cfg.ecc && s.cfg.split_read_write_port_mode) ? `DPBF_WMAX     // see R14
        : eff_w(s.cfg.wid_b, s.cfg.split && !s.cfg.split_read_write_port_mode); // see R07 R09
    if (s.cfg.fifo) wbw = wa;                                              // see R18
    half_b = !s.cfg.split_read_write_port_mode;
    own_a  = !s.cfg.casc || wa != 3'h0 || addr_a_i[`DPBF_CASC] == s.cfg.casc_up; // see R12
    own_b  = !s.cfg.casc || wbw != 3'h0 || addr_b_i[`DPBF_CASC] == s.cfg.casc_up;
    a_wr   = !s.cfg.fifo && en_a_i && we_a_i && own_a;
    depth  = s.cfg.split ? (`DPBF_DEPTH >> 1) >> wa : `DPBF_DEPTH >> wa;

    // Register slave
    wbreq = wb_cyc_i && wb_stb_i && !s.ack;
    if (wbreq) begin
      n.ack = 1'b1;
      unique case (wb_adr_i)
        `DPBF_A_CFG: tmp32 = s.cfg;
        `DPBF_A_AFL: tmp32 = {16'h0000, s.afl};
        `DPBF_A_AEL: tmp32 = {16'h0000, s.ael};
        `DPBF_A_STA: tmp32 = {26'h0, s.dbe_st, s.sbe_st, s.aempty, s.afull, s.empty, s.full};
        `DPBF_A_CNT: tmp32 = {16'h0000, s.cnt};
        default:     tmp32 = '0;
      endcase
      n.dat = tmp32;
      if (wb_we_i) begin
        tmp32 = bmerge(tmp32, wb_dat_i, wb_sel_i);
        unique case (wb_adr_i)
          `DPBF_A_CFG: begin
            n.cfg  = tmp32;
            cfg_wr = 1'b1;
          end
          `DPBF_A_AFL: n.afl = tmp32[15:0];                                // see R17
          `DPBF_A_AEL: n.ael = tmp32[15:0];                                // see R17
          `DPBF_A_STA: clr = wb_dat_i & {30'h0, wb_sel_i[0], wb_sel_i[0]} << 4;
          default: ;
        endcase
      end
    end

    // Port A: shared array, own address and output
    if (!s.cfg.fifo && en_a_i) begin                                       // see R01 R02
      row_a = row_of(addr_a_i, wa, s.cfg.split, 1'b0);
      raw   = s.mem[row_a];
      rdv   = rd_word(raw, addr_a_i, wa);
      wd    = din_a_i;
      if (s.cfg.ecc && s.cfg.split_read_write_port_mode) begin
        wd[71:64] = ecc_enc(din_a_i[63:0]);                                // see R13
      end
      if (a_wr) n.mem[row_a] = wr_row(n.mem[row_a], addr_a_i, wa, wd);
      if (!s.cfg.split_read_write_port_mode) begin
        if (!we_a_i) n.lat_a = rdv;                                        // see R03
        else if (s.cfg.pol_a == DPBF_POL_READ) n.lat_a = rdv;              // see R05
        else if (s.cfg.pol_a == DPBF_POL_WRITE) n.lat_a = rd_word(wr_row(raw, addr_a_i, wa, wd),
                                                                  addr_a_i, wa);
      end
      n.sel_a = own_a;
    end
    if (s.cfg.ecc) n.par = ecc_enc(din_a_i[63:0]);                         // see R14

    // Port B: read-only in split read/write mode
    if (!s.cfg.fifo && en_b_i) begin
      row_b = row_of(addr_b_i, wbw, s.cfg.split, half_b);
      raw   = s.mem[row_b];
      rdv   = rd_word(raw, addr_b_i, wbw);
      if (s.cfg.split_read_write_port_mode) begin
        if (!a_wr) begin                                                   // see R11
          if (s.cfg.ecc) begin
            fix   = ecc_fix(rdv);                                          // see R13
            rdv   = fix[71:0];
            n.sbe = fix[72];
            n.dbe = fix[73];
          end
          n.lat_b = rdv;
        end
      end else begin
        if (we_b_i && own_b) n.mem[row_b] = wr_row(n.mem[row_b], addr_b_i, wbw, din_b_i);
        if (!we_b_i) n.lat_b = rdv;                                        // see R03
        else if (s.cfg.pol_b == DPBF_POL_READ) n.lat_b = rdv;              // see R05
        else if (s.cfg.pol_b == DPBF_POL_WRITE) n.lat_b = rd_word(wr_row(raw, addr_b_i, wbw,
                                                                  din_b_i), addr_b_i, wbw);
      end
      n.sel_b = own_b;
    end

    // FIFO controller on the same array
    wv        = s.cfg.async ? g2b(s.wsync2) : s.wptr;
    mem_empty = (wv - s.rptr) == 16'h0000;
    if (s.cfg.fifo) begin
      if (fifo_wr_i && !s.full) begin                                      // see R21
        row_a = row_of(s.wptr, wa, s.cfg.split, 1'b0);
        n.mem[row_a] = wr_row(s.mem[row_a], s.wptr, wa, din_a_i);
        n.wptr = s.wptr + 16'h0001;                                        // see R15
      end
      if (s.cfg.fwft) begin
        pop = !mem_empty && (!s.fwv || fifo_rd_i);                         // see R19 R20
        if (fifo_rd_i && s.fwv && !pop) n.fwv = 1'b0;
      end else begin
        pop = fifo_rd_i && !s.empty;                                       // see R21
      end
      if (pop) begin
        row_b   = row_of(s.rptr, wa, s.cfg.split, 1'b0);
        n.lat_b = rd_word(s.mem[row_b], s.rptr, wa);
        n.rptr  = s.rptr + 16'h0001;
        n.fwv   = 1'b1;
      end
    end
    if (cfg_wr) begin
      n.wptr = '0;
      n.rptr = '0;
      n.fwv  = 1'b0;
    end

    // Gray pointers cross through two stages
    n.wg     = b2g(n.wptr);                                                // see R22
    n.rg     = b2g(n.rptr);
    n.wsync1 = s.wg;
    n.wsync2 = s.wsync1;
    n.rsync1 = s.rg;
    n.rsync2 = s.rsync1;
    if (cfg_wr) begin
      n.wg     = '0;
      n.rg     = '0;
      n.wsync1 = '0;
      n.wsync2 = '0;
      n.rsync1 = '0;
      n.rsync2 = '0;
    end

    // Occupancy flags on each side
    rv       = s.cfg.async ? g2b(s.rsync2) : n.rptr;                       // see R22
    wv       = s.cfg.async ? g2b(s.wsync2) : n.wptr;
    wcnt     = n.wptr - rv;
    rcnt     = wv - n.rptr;
    n.full   = wcnt >= depth;                                              // see R16
    n.afull  = wcnt >= n.afl;                                              // see R17
    n.empty  = s.cfg.fwft ? !n.fwv : rcnt == 16'h0000;                     // see R19
    n.aempty = rcnt <= n.ael;
    n.cnt    = rcnt;

    // Output stage, optional extra register and cascade pick
    n.out_a = (s.cfg.oreg_a || s.cfg.casc) ? s.lat_a : n.lat_a;            // see R04
    n.out_b = (s.cfg.oreg_b || s.cfg.casc) ? s.lat_b : n.lat_b;            // see R04
    if (s.cfg.casc && !s.sel_a) n.out_a = {71'h0, casc_a_i};               // see R12
    if (s.cfg.casc && !s.sel_b) n.out_b = {71'h0, casc_b_i};
    n.casc_a = n.lat_a[0];
    n.casc_b = n.lat_b[0];

    // Sticky error bits, set wins over clear
    n.sbe_st = (s.sbe_st & !clr[4]) | n.sbe;
    n.dbe_st = (s.dbe_st & !clr[5]) | n.dbe;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s        <= '0;
      s.afl    <= `DPBF_AFL_RST;
      s.ael    <= `DPBF_AEL_RST;
      s.empty  <= 1'b1;
      s.aempty <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from state
  assign wb_dat_o     = s.dat;
  assign wb_ack_o     = s.ack;
  assign dout_a_o     = s.out_a;
  assign dout_b_o     = s.out_b;
  assign casc_a_o     = s.casc_a;
  assign casc_b_o     = s.casc_b;
  assign full_o       = s.full;
  assign empty_o      = s.empty;
  assign afull_o      = s.afull;
  assign aempty_o     = s.aempty;
  assign sbiterr_o    = s.sbe;
  assign dbiterr_o    = s.dbe;
  assign ecc_parity_o = s.par;

endmodule : dpbf_top

// ===== testbench/dpbf_top_assertions.sv
`timescale 1ns/100ps
module dpbf_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        en_a_i,
  input wire logic        en_b_i,
  input wire logic        fifo_wr_i,
  input wire logic        fifo_rd_i,
  input wire logic [71:0] dout_a_o,
  input wire logic [71:0] dout_b_o,
  input wire logic        full_o,
  input wire logic        empty_o,
  input wire logic        afull_o,
  input wire logic        aempty_o,
  input wire logic        sbiterr_o,
  input wire logic        dbiterr_o
);
  // One clock domain, checks off during reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus request still waiting for its answer
  sequence wb_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  // Cycles in which nothing may move a port output
  sequence a_quiet; !en_a_i && !fifo_wr_i && !wb_stb_i; endsequence
  sequence b_quiet; !en_b_i && !fifo_rd_i && !fifo_wr_i && !wb_stb_i; endsequence

  chk_ack_next: assert property (wb_req |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  chk_hold_a: assert property (a_quiet [*3] |=> $stable(dout_a_o))
    else $error("port a output moved while idle");
  chk_hold_b: assert property (b_quiet [*3] |=> $stable(dout_b_o))
    else $error("port b output moved while idle");
  chk_flag_excl: assert property (!(full_o && empty_o))
    else $error("full and empty together");
  chk_empty_low: assert property (empty_o |-> aempty_o)
    else $error("empty without almost empty");
  chk_pop_empty: assert property (empty_o && !fifo_wr_i && !$past(fifo_wr_i) && !wb_stb_i
                                  |=> empty_o)
    else $error("pop on empty changed state");
  chk_push_full: assert property (full_o && !fifo_rd_i && !wb_stb_i |=> full_o)
    else $error("push on full changed state");
  chk_ecc_excl: assert property (!(sbiterr_o && dbiterr_o))
    else $error("single and double error together");
  chk_reset_flags: assert property ($past(rst_i) |-> empty_o && aempty_o && !full_o && !afull_o)
    else $error("flags wrong after reset");
endmodule : dpbf_chk

bind dpbf_top dpbf_chk i_dpbf_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .en_a_i(en_a_i), .en_b_i(en_b_i), .fifo_wr_i(fifo_wr_i),
  .fifo_rd_i(fifo_rd_i), .dout_a_o(dout_a_o), .dout_b_o(dout_b_o), .full_o(full_o),
  .empty_o(empty_o), .afull_o(afull_o), .aempty_o(aempty_o), .sbiterr_o(sbiterr_o),
  .dbiterr_o(dbiterr_o));

// ===== testbench/dpbf_user.sv
`timescale 1ns/100ps
module dpbf_user (
  input  wire logic        clk_i,
  output logic             en_a_o,
  output logic             we_a_o,
  output logic [15:0]      addr_a_o,
  output logic [71:0]      din_a_o,
  output logic             en_b_o,
  output logic             we_b_o,
  output logic [15:0]      addr_b_o,
  output logic [71:0]      din_b_o,
  output logic             fifo_wr_o,
  output logic             fifo_rd_o
);
  // Quiet start
  initial begin
    {en_a_o, we_a_o, en_b_o, we_b_o, fifo_wr_o, fifo_rd_o} = 6'h00;
    addr_a_o = 16'h0000;
    addr_b_o = 16'h0000;
    din_a_o = 72'h0;
    din_b_o = 72'h0;
  end

  // One request for one edge; released data toggles
  task automatic drive(input logic [5:0] c, input logic [15:0] aa, ab, input logic [71:0] da);
    {en_a_o, we_a_o, en_b_o, we_b_o, fifo_wr_o, fifo_rd_o} <= c;
    addr_a_o <= aa;
    addr_b_o <= ab;
    din_a_o <= (c == 6'h00) ? ~din_a_o : da;
    din_b_o <= ~din_b_o;
    @(posedge clk_i);
  endtask : drive
endmodule : dpbf_user

// ===== testbench/tb.sv
`timescale 1ns/100ps
`include "dpbf_defs.svh"
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        en_a, we_a, en_b, we_b, fwr, frd, full, empty, afull, aempty, sbe, dbe;
  logic [15:0] addr_a, addr_b;
  logic [71:0] din_a, din_b, dout_a, dout_b, m, o, e;
  int          n_mismatch = 0;
  int          n_compared = 0;
  logic [7:0]  adr [5] = '{`DPBF_A_CFG, `DPBF_A_AFL, `DPBF_A_AEL, `DPBF_A_STA, 8'h14};
  logic [31:0] rv [5] = '{32'h0, 32'(`DPBF_AFL_RST), 32'(`DPBF_AEL_RST), 32'ha, 32'h0};

  // 250 MHz clock
  always #2 clk_i = ~clk_i;

  dpbf_top i_dpbf_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .en_a_i(en_a), .we_a_i(we_a), .addr_a_i(addr_a),
    .din_a_i(din_a), .dout_a_o(dout_a), .casc_a_i(1'b0), .casc_a_o(), .en_b_i(en_b),
    .we_b_i(we_b), .addr_b_i(addr_b), .din_b_i(din_b), .dout_b_o(dout_b), .casc_b_i(1'b0),
    .casc_b_o(), .fifo_wr_i(fwr), .fifo_rd_i(frd), .full_o(full), .empty_o(empty),
    .afull_o(afull), .aempty_o(aempty), .sbiterr_o(sbe), .dbiterr_o(dbe), .ecc_parity_o());

  dpbf_user i_dpbf_user (.clk_i(clk_i), .en_a_o(en_a), .we_a_o(we_a), .addr_a_o(addr_a),
    .din_a_o(din_a), .en_b_o(en_b), .we_b_o(we_b), .addr_b_o(addr_b), .din_b_o(din_b),
    .fifo_wr_o(fwr), .fifo_rd_o(frd));

  // Compare and count
  task automatic chk(input string nm, input logic [71:0] x, g);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask : chk

  // Classic single bus cycle, waits for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // One port step; op follows it with one idle step
  task automatic go(input logic [5:0] c, input logic [15:0] aa, ab, input logic [71:0] da);
    i_dpbf_user.drive(c, aa, ab, da);
  endtask : go

  task automatic op(input logic [5:0] c, input logic [15:0] aa, ab, input logic [71:0] da);
    go(c, aa, ab, da);
    go(6'h00, aa, ab, da);
  endtask : op

  function automatic logic [71:0] dv(input int n);
    return {8'(n * 3), {4{16'(n * 40503)}}};
  endfunction : dv

  // Verdict
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, 8'h14, 32'hffff_ffff);
    foreach (adr[i]) begin
      wb(1'b0, adr[i], 32'h0);
      chk("reg", 72'(rv[i]), 72'(rd));
    end
    wb(1'b1, `DPBF_A_CFG, 32'h36);
    op(6'h30, 16'd5, 16'd0, dv(1));
    op(6'h08, 16'd0, 16'd5, 72'h0);
    chk("dout_b", dv(1), dout_b);
    op(6'h30, 16'd5, 16'd0, dv(2));
    chk("dout_b", dv(1), dout_b);
    m = dv(2);
    op(6'h20, 16'd5, 16'd0, 72'h0);
    o = m;
    for (int p = 0; p < 3; p++) begin
      wb(1'b1, `DPBF_A_CFG, 32'h36 | (p << 6));
      e = (p == 0) ? m : ((p == 1) ? dv(10 + p) : o);
      op(6'h30, 16'd5, 16'd0, dv(10 + p));
      chk("dout_a", e, dout_a);
      o = e;
      m = dv(10 + p);
    end
    wb(1'b1, `DPBF_A_CFG, 32'h436);
    go(6'h20, 16'd5, 16'd0, 72'h0);
    go(6'h00, 16'd5, 16'd0, 72'h0);
    chk("dout_a", o, dout_a);
    go(6'h00, 16'd5, 16'd0, 72'h0);
    chk("dout_a", m, dout_a);
    wb(1'b1, `DPBF_A_CFG, 32'h1e);
    op(6'h30, 16'd5, 16'd0, dv(5));
    op(6'h08, 16'd0, 16'd42, 72'h0);
    e = dv(5);
    chk("lane", {7'h0, e[66], 56'h0, e[23:16]}, dout_b & {7'h0, 1'b1, 56'h0, 8'hff});
    wb(1'b1, `DPBF_A_CFG, 32'h2036);
    op(6'h30, 16'd5, 16'd0, dv(3));
    op(6'h08, 16'd0, 16'd5, 72'h0);
    chk("dout_b", dv(3), dout_b);
    op(6'h38, 16'd5, 16'd5, dv(4));
    chk("dout_b", dv(3), dout_b);
    // Store with check bits, read raw, plant a one-bit error, read corrected
    wb(1'b1, `DPBF_A_CFG, 32'h6036);
    op(6'h30, 16'd7, 16'd0, dv(6));
    wb(1'b1, `DPBF_A_CFG, 32'h2036);
    op(6'h08, 16'd0, 16'd7, 72'h0);
    m = dout_b;
    e = dv(6);
    chk("ecc_store", 72'(e[63:0]), 72'(m[63:0]));
    op(6'h30, 16'd7, 16'd0, {m[71:1], ~m[0]});
    wb(1'b1, `DPBF_A_CFG, 32'h6036);
    op(6'h08, 16'd0, 16'd7, 72'h0);
    chk("ecc_fix", 72'(e[63:0]), 72'(dout_b[63:0]));
    chk("sbiterr", 72'h1, 72'(sbe));
    chk("dbiterr", 72'h0, 72'(dbe));
    wb(1'b0, `DPBF_A_STA, 32'h0);
    chk("sticky", 72'h1, 72'(rd[4]));
    wb(1'b1, `DPBF_A_CFG, 32'h8036);
    wb(1'b1, `DPBF_A_AFL, 32'h4);
    wb(1'b1, `DPBF_A_AEL, 32'h1);
    for (int k = 1; k <= 512; k++) begin
      go(6'h02, 16'd0, 16'd0, dv(k));
      chk("flags", 72'({full, empty, afull, aempty}), 72'({1'b0, k == 1, k >= 5, k <= 2}));
    end
    op(6'h02, 16'd0, 16'd0, dv(999));
    chk("full", 72'h1, 72'(full));
    wb(1'b0, `DPBF_A_CNT, 32'h0);
    chk("count", 72'h200, 72'(rd));
    for (int k = 1; k <= 512; k++) begin
      op(6'h01, 16'd0, 16'd0, 72'h0);
      chk("fifo_out", dv(k), dout_b);
      chk("flags", 72'({full, empty, afull, aempty}),
          72'({1'b0, k == 512, 512 - k >= 4, 512 - k <= 1}));
    end
    op(6'h01, 16'd0, 16'd0, 72'h0);
    chk("fifo_out", dv(512), dout_b);
    wb(1'b1, `DPBF_A_CFG, 32'h18036);
    go(6'h02, 16'd0, 16'd0, dv(20));
    go(6'h02, 16'd0, 16'd0, dv(21));
    repeat (4) go(6'h00, 16'd0, 16'd0, 72'h0);
    chk("fwft_out", dv(20), dout_b);
    op(6'h01, 16'd0, 16'd0, 72'h0);
    chk("fwft_out", dv(21), dout_b);
    op(6'h01, 16'd0, 16'd0, 72'h0);
    chk("empty", 72'h1, 72'(empty));
    test_done();
  end
endmodule : tb
